// ### dv/clock_regs_props.sv
// Assertion checker for the clock register block, bound into its top
`timescale 1ns/100ps
module clock_regs_props (
    // Clock, reset and register access
    input wire logic                        clk_sys_in,
    input wire logic                        rstn_in,
    input wire clock_regs_pkg::sfr_req_type sfr_req_in,
    input wire logic [7:0]                  sfr_rdata_out,
    // Pins
    input wire logic                        lf_clk_in,
    input wire logic                        pwm_in,
    input wire logic                        pwm_sel_in,
    input wire logic                        test_pin_out,
    input wire logic                        irq_out
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    logic [4:0] pass_r;
    logic [1:0] mode_r;
    logic       open_r;
    logic [7:0] wcnt_r;
    logic [7:0] ctl_r;
    logic [7:0] en_r;

    // Decoded view of the request
    wire logic [7:0] addr_w   = sfr_req_in.addr;
    wire logic [7:0] wdata_w  = sfr_req_in.wdata;
    wire logic [4:0] key_w    = wdata_w[7:3];
    wire logic       key_wr_w = sfr_req_in.wr
                                && addr_w == clock_regs_pkg::ADDR_PROTECT;
    wire logic       opens_w  = key_wr_w
                                && mode_r == clock_regs_pkg::MODE_OPEN
                                && (key_w == clock_regs_pkg::PASS_OPEN
                                || key_w == clock_regs_pkg::PASS_CLOCK);
    wire logic       expire_w = open_r && wcnt_r == 8'h7F && !key_wr_w;
    wire logic       mapped_w = addr_w inside {8'h9A, 8'hAA, 8'hB2,
                                [8'hF1:8'hF5], [8'hF9:8'hFF]};

    // Shadow of the key register; the old key gates a mode change,
    // so the mode password must already be stored
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pass_r <= 5'h00;
            mode_r <= 2'h0;
            open_r <= 1'b0;
            wcnt_r <= 8'h00;
        end else if (expire_w) begin
            pass_r <= 5'h00;
            mode_r <= 2'h0;
            open_r <= 1'b0;
        end else if (key_wr_w) begin
            pass_r <= key_w;
            mode_r <= (pass_r == clock_regs_pkg::PASS_MODE) ?
                      wdata_w[1:0] : mode_r;
            open_r <= opens_w
                      || (open_r && !(key_w == clock_regs_pkg::PASS_CLOSE
                      && mode_r == clock_regs_pkg::MODE_OPEN));
            wcnt_r <= opens_w ? 8'h00 : wcnt_r + 8'h01;
        end else begin
            wcnt_r <= wcnt_r + 8'h01;
        end
    end

    // Written control and enable values; control bit 7 never sticks
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_r <= 8'h00;
            en_r  <= 8'h00;
        end else if (sfr_req_in.wr) begin
            ctl_r <= (addr_w == clock_regs_pkg::ADDR_CONTROL) ?
                     (wdata_w & 8'h7F) : ctl_r;
            en_r  <= (addr_w == clock_regs_pkg::ADDR_IRQ_EN) ? wdata_w : en_r;
        end
    end

    // Trim writes followed by a readback of the same register
    sequence locked_trim_s;
        sfr_req_in.wr && addr_w == clock_regs_pkg::ADDR_TRIM && !open_r
        ##1 addr_w == clock_regs_pkg::ADDR_TRIM;
    endsequence
    sequence open_trim_s;
        sfr_req_in.wr && addr_w == clock_regs_pkg::ADDR_TRIM && open_r
        ##1 addr_w == clock_regs_pkg::ADDR_TRIM;
    endsequence

    trim_locked_a: assert property (
        locked_trim_s |-> sfr_rdata_out == $past(sfr_rdata_out))
        else $error("trim changed while locked");
    trim_open_a: assert property (
        open_trim_s |-> sfr_rdata_out == $past(wdata_w))
        else $error("trim write lost in open window");
    sec_range_a: assert property (
        sfr_req_in.wr && addr_w == clock_regs_pkg::ADDR_SEC
        && wdata_w > clock_regs_pkg::MAX_SEC ##1
        addr_w == clock_regs_pkg::ADDR_SEC |-> $stable(sfr_rdata_out))
        else $error("out of range seconds stored");
    protect_state_a: assert property (
        addr_w == clock_regs_pkg::ADDR_PROTECT |-> sfr_rdata_out[2] == open_r)
        else $error("protect state bit wrong");
    window_expire_a: assert property (
        expire_w ##1 addr_w == clock_regs_pkg::ADDR_PROTECT
        |-> sfr_rdata_out == clock_regs_pkg::RESET_BYTE)
        else $error("key register not cleared at timeout");
    unmapped_zero_a: assert property (
        !mapped_w |-> sfr_rdata_out == 8'h00)
        else $error("unmapped address reads nonzero");
    flags_ro_a: assert property (
        sfr_req_in.wr && addr_w == clock_regs_pkg::ADDR_IRQ_FLAG ##1
        addr_w == clock_regs_pkg::ADDR_IRQ_FLAG |-> $stable(sfr_rdata_out))
        else $error("flag register took a write");
    pin_low_a: assert property (
        (ctl_r[6:5] == 2'b00 && !pwm_sel_in)[*3] |-> !test_pin_out)
        else $error("test pin not low");
    pin_high_a: assert property (
        (ctl_r[6:5] == 2'b01 && !pwm_sel_in)[*3] |-> test_pin_out)
        else $error("test pin not high");
    pin_share_a: assert property (
        pwm_sel_in && $past(pwm_sel_in) |-> test_pin_out == $past(pwm_in))
        else $error("test pin not following pulse output");
    irq_masked_a: assert property (
        en_r == 8'h00 |-> !irq_out)
        else $error("interrupt with all enables clear");
endmodule

bind clock_regs clock_regs_props props (
    .clk_sys_in, .rstn_in, .sfr_req_in, .sfr_rdata_out, .lf_clk_in,
    .pwm_in, .pwm_sel_in, .test_pin_out, .irq_out
);

// ### dv/clock_regs_tb.sv
// Self-checking bench for the clock register block
`timescale 1ns/100ps
module clock_regs_tb;
    logic                        clk_sys_in = 1'b0;
    logic                        rstn_in    = 1'b0;
    logic                        lf_clk_in  = 1'b0;
    logic                        pwm_in     = 1'b0;
    logic                        pwm_sel_in = 1'b0;
    clock_regs_pkg::sfr_req_type req        = '0;
    logic [7:0]                  rdata;
    logic                        test_pin;
    logic                        irq;
    logic                        prev;
    logic [7:0]                  tmp;
    logic [7:0]                  exp_q[$];
    int                          n_errors = 0;
    int                          compares = 0;
    int                          seed     = 61069;
    int                          edges;
    // Reset values, then writes in an open window with expected readback
    logic [7:0] ra[10] = '{8'h9A, 8'hAA, 8'hB2, 8'hF1, 8'hF2, 8'hF9,
                           8'hFC, 8'hFD, 8'hF6, 8'h00};
    logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h01, 8'h01, 8'h00, 8'h00};
    logic [7:0] ta[24] = '{8'hF9, 8'hF9, 8'hFA, 8'hFA, 8'hFB, 8'hFB,
        8'hFD, 8'hFD, 8'hFC, 8'hFC, 8'hFD, 8'hFE, 8'hFC, 8'hFE, 8'hFC,
        8'hFC, 8'hFE, 8'hFF, 8'hFF, 8'hF4, 8'hF4, 8'hF5, 8'hF5, 8'hF3};
    logic [7:0] td[24] = '{8'h3B, 8'h3C, 8'h00, 8'hFF, 8'h17, 8'h18,
        8'h0C, 8'h0D, 8'h1F, 8'h01, 8'h02, 8'h01, 8'h1D, 8'h04, 8'h1D,
        8'h01, 8'h7F, 8'h06, 8'h07, 8'h3B, 8'h3C, 8'h17, 8'h18, 8'hFF};
    logic [7:0] te[24] = '{8'h3B, 8'h3B, 8'h00, 8'h00, 8'h17, 8'h17,
        8'h0C, 8'h0C, 8'h1F, 8'h01, 8'h02, 8'h01, 8'h01, 8'h04, 8'h1D,
        8'h01, 8'h7F, 8'h06, 8'h06, 8'h3B, 8'h3B, 8'h17, 8'h17, 8'h3F};

    clock_regs dut (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .sfr_req_in(req),
        .sfr_rdata_out(rdata), .lf_clk_in(lf_clk_in), .pwm_in(pwm_in),
        .pwm_sel_in(pwm_sel_in), .test_pin_out(test_pin), .irq_out(irq));

    always #2.5 clk_sys_in = ~clk_sys_in;
    // Crystal sped up so timer flags fall inside the run; its period
    // is no multiple of the system clock
    always #21.3 lf_clk_in = ~lf_clk_in;

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d, n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Requests change only at the falling edge; back-to-back is allowed
    task automatic bus(input logic w, input logic r, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge clk_sys_in);
        req = '{w, r, a, d};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic open_win;
        wr(8'h9A, 8'hC0);
        wr(8'h9A, 8'hC3);
        wr(8'h9A, 8'h9B);
    endtask

    // Each read strobe yields one result; pair it with the oldest note
    always @(posedge clk_sys_in) begin
        if (req.rd === 1'b1 && exp_q.size() > 0) begin
            check(rdata, exp_q.pop_front());
        end
    end

    // Whole run is about 17.5k cycles; this cuts a hang short
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rstn_in = 1'b1;
        foreach (ra[i]) rd(ra[i], rv[i]);
        wr(8'hF2, 8'h5A);
        rd(8'hF2, 8'h00);
        wr(8'hB2, 8'hFF);
        rd(8'hB2, 8'h00);
        wr(8'hF1, 8'hFF);
        rd(8'hF1, 8'h7F);
        open_win();
        rd(8'h9A, 8'h9F);
        foreach (ta[i]) begin
            wr(ta[i], td[i]);
            rd(ta[i], te[i]);
        end
        repeat (4) begin
            tmp = 8'($random(seed));
            wr(8'hF2, tmp);
            rd(8'hF2, tmp);
        end
        // Window lapses exactly 128 cycles after the opening write
        wr(8'h9A, 8'h98);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (126) @(negedge clk_sys_in);
        rd(8'h9A, 8'h9F);
        rd(8'h9A, 8'h00);
        wr(8'hF2, 8'h33);
        rd(8'hF2, tmp);
        open_win();
        wr(8'h9A, 8'h88);
        rd(8'h9A, 8'h8F);
        wr(8'hF2, 8'h81);
        rd(8'hF2, 8'h81);
        wr(8'h9A, 8'hA8);
        rd(8'h9A, 8'hAB);
        wr(8'h9A, 8'hC0);
        wr(8'h9A, 8'hC2);
        wr(8'h9A, 8'h9A);
        rd(8'h9A, 8'h9A);
        wr(8'hF2, 8'h7E);
        rd(8'hF2, 8'h81);
        tmp = 8'($random(seed));
        wr(8'hAA, tmp);
        rd(8'hAA, tmp);
        check({7'h00, irq}, 8'h00);
        wr(8'hAA, 8'h00);
        for (int m = 0; m < 2; m++) begin
            wr(8'hF1, {2'h0, m[0], 5'h00});
            repeat (4) @(negedge clk_sys_in);
            check({7'h00, test_pin}, {7'h00, m[0]});
        end
        // Pulse output owns the pin one register stage later
        pwm_sel_in = 1'b1;
        repeat (8) begin
            @(negedge clk_sys_in);
            check({7'h00, test_pin}, {7'h00, pwm_in});
            pwm_in = 1'($random(seed));
        end
        @(negedge clk_sys_in);
        pwm_sel_in = 1'b0;
        for (int f = 0; f < 8; f++) begin
            wr(8'hF1, 8'(8'h40 + f));
            rd(8'hF1, 8'(8'h40 + f));
        end
        // Crystal rate on the pin: four rising edges in four periods
        for (int m = 0; m < 2; m++) begin
            wr(8'hF1, {1'b0, 1'b1, m[0], 5'h07});
            repeat (6) @(negedge clk_sys_in);
            edges = 0;
            prev = test_pin;
            repeat (34) begin
                @(negedge clk_sys_in);
                edges += int'(test_pin && !prev);
                prev = test_pin;
            end
            check(8'(edges >= 3 && edges <= 5), 8'h01);
        end
        // Fast timer two flag raises the request once enabled
        wr(8'hF1, 8'h08);
        wr(8'hAA, 8'h20);
        edges = 0;
        while (irq !== 1'b1 && edges < 20000) begin
            @(negedge clk_sys_in);
            edges++;
        end
        check({7'h00, irq}, 8'h01);
        rd(8'hB2, 8'h20);
        rd(8'hFD, 8'h02);
        rd(8'hB2, 8'h00);
        check({7'h00, irq}, 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (4) @(negedge clk_sys_in);
        complete_run();
    end
endmodule

// ### logic/clock_regs.sv
// Real-time clock register block with password write protection
`timescale 1ns/100ps
module clock_regs #(
    parameter int LF_HZ = 32768
) (
    // System clock and reset
    input  wire logic                        clk_sys_in,
    input  wire logic                        rstn_in,
    // Special function register access
    input  wire clock_regs_pkg::sfr_req_type sfr_req_in,
    output logic [7:0]                       sfr_rdata_out,
    // Low frequency crystal clock, asynchronous
    input  wire logic                        lf_clk_in,
    // Test pin and shared pulse-width output
    input  wire logic                        pwm_in,
    input  wire logic                        pwm_sel_in,
    output logic                             test_pin_out,
    // Interrupt request
    output logic                             irq_out
);
    // Divider taps assume the standard crystal rate
    if (LF_HZ != 32768) begin : g_lf_check
        $error("only 32768 Hz supported");
    end

    // Synchronise the slow clock and detect its rising edge
    logic       lf_s1_r;
    logic       lf_s2_r;
    logic       lf_s3_r;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lf_s1_r <= 1'b0;
            lf_s2_r <= 1'b0;
            lf_s3_r <= 1'b0;
        end else begin
            lf_s1_r <= lf_clk_in;
            lf_s2_r <= lf_s1_r;
            lf_s3_r <= lf_s2_r;
        end
    end
    wire lf_tick = lf_s2_r & ~lf_s3_r;

    // Registers
    logic [7:0] protect_r;
    logic [7:0] ien_r;
    logic [7:0] flag_r;
    logic [7:0] ctl_r;
    logic [7:0] trim_r;
    logic [5:0] sec_lim_r;
    logic [5:0] alm_min_r;
    logic [4:0] alm_hr_r;
    logic [5:0] sec_r;
    logic [5:0] min_r;
    logic [4:0] hr_r;
    logic [4:0] day_r;
    logic [3:0] mon_r;
    logic [6:0] year_r;
    logic [2:0] wday_r;
    logic [7:0] win_cnt_r;
    logic       wopen_r;
    logic [7:0] armed_r;
    logic [15:0] div_r;
    logic [15:0] div_top_r;
    logic [5:0] scnt_r;
    logic [3:0] trim_sec_r;

    // Address decode
    wire wr = sfr_req_in.wr;
    wire rd = sfr_req_in.rd;
    wire [7:0] a = sfr_req_in.addr;
    wire [7:0] d = sfr_req_in.wdata;
    wire wr_prot = wr && a == clock_regs_pkg::ADDR_PROTECT;
    // Protected writes land only inside an open window
    wire pw = wr && wopen_r;

    // Days in current month, leap year every fourth year from 2000
    logic [4:0] mdays;
    always_comb begin
        case (mon_r)
            4'h2:    mdays = (year_r[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            4'h4, 4'h6, 4'h9, 4'hB: mdays = 5'h1E;
            default: mdays = 5'h1F;
        endcase
    end

    // Write range checks
    wire ok_min  = d <= clock_regs_pkg::MAX_SEC;
    wire ok_hr   = d <= clock_regs_pkg::MAX_HR;
    wire ok_day  = d >= 8'h01 && d <= {3'h0, mdays};
    wire ok_mon  = d <= clock_regs_pkg::MAX_MON;
    wire ok_year = d <= clock_regs_pkg::MAX_YEAR;
    wire ok_wday = d <= clock_regs_pkg::MAX_WDAY;

    // Protect register next state: mode, password, window
    wire [4:0] pass_cur = protect_r[7:3];
    wire [4:0] pass_new = d[7:3];
    wire       mode_ok  = protect_r[1:0] == clock_regs_pkg::MODE_OPEN;
    wire       opening  = wr_prot && mode_ok &&
        (pass_new == clock_regs_pkg::PASS_OPEN ||
         pass_new == clock_regs_pkg::PASS_CLOCK);
    wire       win_end  = wopen_r &&
        win_cnt_r == 8'(clock_regs_pkg::WINDOW_CYCLES - 1);
    logic [7:0] protect_nxt;
    logic       wopen_nxt;
    always_comb begin
        protect_nxt = protect_r;
        wopen_nxt   = wopen_r;
        if (wr_prot) begin
            protect_nxt[7:3] = pass_new;
            if (pass_cur == clock_regs_pkg::PASS_MODE)
                protect_nxt[1:0] = d[1:0];
            if (opening)
                wopen_nxt = 1'b1;
            else if (mode_ok && pass_new == clock_regs_pkg::PASS_CLOSE)
                wopen_nxt = 1'b0;
        end else if (win_end) begin
            protect_nxt = clock_regs_pkg::RESET_BYTE;
            wopen_nxt   = 1'b0;
        end
        protect_nxt[2] = wopen_nxt;
    end

    // Protect window counter restarts on each opening password
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            protect_r <= clock_regs_pkg::RESET_BYTE;
            wopen_r   <= 1'b0;
            win_cnt_r <= 8'h00;
        end else begin
            protect_r <= protect_nxt;
            wopen_r   <= wopen_nxt;
            win_cnt_r <= opening ? 8'h00 : win_cnt_r + 8'h01;
        end
    end

    // One-second prescaler, adjusted by trim every twelve seconds.
    // Sign 0 removes N slow clocks, sign 1 adds the negated amount.
    wire [6:0] trim_n = trim_r[7] ? 7'(~trim_r[6:0] + 7'h01)
                                  : trim_r[6:0];
    // Spare divider bit keeps an added trim from wrapping the second
    wire [15:0] base_top = 16'(LF_HZ - 1);
    wire sec_edge = lf_tick && div_r == div_top_r;
    wire half  = lf_tick && div_r[12:0] == 13'h1FFF; // Quarter-second steps
    wire s8    = lf_tick && div_r[11:0] == 12'hFFF;
    wire s16   = lf_tick && div_r[10:0] == 11'h7FF;
    wire t1_ev = ctl_r[clock_regs_pkg::CTL_TICK]
               ? s8 : (lf_tick && div_r[13:0] == 14'h3FFF);
    wire t2_ev = ctl_r[clock_regs_pkg::CTL_TICK] ? s16 : half;

    // Calendar carries
    wire min_ev  = sec_edge && sec_r == clock_regs_pkg::MAX_SEC[5:0];
    wire hr_ev   = min_ev && min_r == clock_regs_pkg::MAX_SEC[5:0];
    wire day_ev  = hr_ev && hr_r == clock_regs_pkg::MAX_HR[4:0];
    wire mon_ev  = day_ev && day_r >= mdays;
    wire year_ev = mon_ev && mon_r >= clock_regs_pkg::MAX_MON[3:0];
    wire scnt_ev = sec_edge && ctl_r[clock_regs_pkg::CTL_SCNT_EN] &&
                   scnt_r >= sec_lim_r;
    // Midnight rollover must compare against hour zero, not 24
    wire alm_hit = sec_edge && sec_r == clock_regs_pkg::MAX_SEC[5:0] &&
                   (day_ev ? 5'h00 : hr_ev ? 5'(hr_r + 5'h01)
                                           : hr_r) == alm_hr_r &&
                   (hr_ev ? 6'h00 : 6'(min_r + 6'h01)) == alm_min_r;

    // Timekeeping runs unconditionally in all power modes
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_r      <= 16'h0000;
            div_top_r  <= 16'h7FFF;
            trim_sec_r <= 4'h0;
            scnt_r     <= 6'h00;
        end else begin
            if (lf_tick)
                div_r <= sec_edge ? 16'h0000 : div_r + 16'h0001;
            if (sec_edge) begin
                trim_sec_r <= (trim_sec_r ==
                    4'(clock_regs_pkg::TRIM_PERIOD_S - 1))
                    ? 4'h0 : trim_sec_r + 4'h1;
                div_top_r <= (trim_sec_r ==
                    4'(clock_regs_pkg::TRIM_PERIOD_S - 2))
                    ? (trim_r[7] ? base_top + 16'(trim_n)
                                 : base_top - 16'(trim_n))
                    : base_top;
                scnt_r <= !ctl_r[clock_regs_pkg::CTL_SCNT_EN] || scnt_ev
                        ? 6'h00 : scnt_r + 6'h01;
            end
        end
    end

    // Time and calendar; written values win over carries
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sec_r  <= 6'h00;
            min_r  <= 6'h00;
            hr_r   <= 5'h00;
            day_r  <= 5'h01;
            mon_r  <= 4'h1;
            year_r <= 7'h00;
            wday_r <= 3'h0;
        end else begin
            if (pw && a == clock_regs_pkg::ADDR_SEC && ok_min)
                sec_r <= d[5:0];
            else if (sec_edge)
                sec_r <= min_ev ? 6'h00 : sec_r + 6'h01;
            if (pw && a == clock_regs_pkg::ADDR_MIN && ok_min)
                min_r <= d[5:0];
            else if (min_ev)
                min_r <= hr_ev ? 6'h00 : min_r + 6'h01;
            if (pw && a == clock_regs_pkg::ADDR_HR && ok_hr)
                hr_r <= d[4:0];
            else if (hr_ev)
                hr_r <= day_ev ? 5'h00 : hr_r + 5'h01;
            if (pw && a == clock_regs_pkg::ADDR_DAY && ok_day)
                day_r <= d[4:0];
            else if (day_ev)
                day_r <= mon_ev ? 5'h01 : day_r + 5'h01;
            if (pw && a == clock_regs_pkg::ADDR_MONTH && ok_mon)
                mon_r <= d[3:0];
            else if (mon_ev)
                mon_r <= year_ev ? 4'h1 : mon_r + 4'h1;
            if (pw && a == clock_regs_pkg::ADDR_YEAR && ok_year)
                year_r <= d[6:0];
            else if (year_ev)
                year_r <= year_r == 7'h63 ? 7'h00 : year_r + 7'h01;
            if (pw && a == clock_regs_pkg::ADDR_WEEKDAY && ok_wday)
                wday_r <= d[2:0];
            else if (day_ev)
                wday_r <= wday_r == 3'h6 ? 3'h0 : wday_r + 3'h1;
        end
    end

    // Plain configuration registers; trim is protected
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ien_r     <= clock_regs_pkg::RESET_BYTE;
            ctl_r     <= clock_regs_pkg::RESET_BYTE;
            trim_r    <= clock_regs_pkg::RESET_BYTE;
            sec_lim_r <= 6'h00;
            alm_min_r <= 6'h00;
            alm_hr_r  <= 5'h00;
        end else begin
            if (wr && a == clock_regs_pkg::ADDR_IRQ_EN)
                ien_r <= d;
            if (wr && a == clock_regs_pkg::ADDR_CONTROL)
                ctl_r <= {1'b0, d[6:0]};
            if (pw && a == clock_regs_pkg::ADDR_TRIM)
                trim_r <= d;
            if (wr && a == clock_regs_pkg::ADDR_SEC_LIM)
                sec_lim_r <= d[5:0];
            if (wr && a == clock_regs_pkg::ADDR_ALM_MIN && ok_min)
                alm_min_r <= d[5:0];
            if (wr && a == clock_regs_pkg::ADDR_ALM_HR && ok_hr)
                alm_hr_r <= d[4:0];
        end
    end

    // Flags: read of flag register arms, read of paired register clears.
    // Set wins over clear so no event is lost.
    wire [7:0] set_v = {alm_hit, scnt_ev, t2_ev, t1_ev,
                        day_ev, hr_ev, min_ev, sec_edge};
    logic [7:0] clr_v;
    always_comb begin
        clr_v = 8'h00;
        if (rd) begin
            case (a)
                clock_regs_pkg::ADDR_ALM_HR:  clr_v[7] = 1'b1;
                clock_regs_pkg::ADDR_SEC_LIM: clr_v[6] = 1'b1;
                clock_regs_pkg::ADDR_MONTH:   clr_v[5] = 1'b1;
                clock_regs_pkg::ADDR_YEAR:    clr_v[4] = 1'b1;
                clock_regs_pkg::ADDR_DAY:     clr_v[3] = 1'b1;
                clock_regs_pkg::ADDR_HR:      clr_v[2] = 1'b1;
                clock_regs_pkg::ADDR_MIN:     clr_v[1] = 1'b1;
                clock_regs_pkg::ADDR_SEC:     clr_v[0] = 1'b1;
                default:                      clr_v = 8'h00;
            endcase
        end
    end
    wire rd_flags = rd && a == clock_regs_pkg::ADDR_IRQ_FLAG;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_r  <= clock_regs_pkg::RESET_BYTE;
            armed_r <= 8'h00;
        end else begin
            flag_r  <= (flag_r & ~(clr_v & armed_r)) | set_v;
            armed_r <= rd_flags ? flag_r : armed_r & ~clr_v;
        end
    end

    // Interrupt request from enabled flags
    assign irq_out = |(flag_r & ien_r);

    // Test pin source: level or selected rate, or pulse-width output
    logic freq_bit;
    always_comb begin
        case (ctl_r[clock_regs_pkg::CTL_FREQ_LSB +: 3])
            3'h0:    freq_bit = div_r[14];
            3'h1:    freq_bit = div_r[13];
            3'h2:    freq_bit = div_r[12];
            3'h3:    freq_bit = div_r[11];
            3'h4:    freq_bit = div_r[9];
            3'h5:    freq_bit = div_r[7];
            3'h6:    freq_bit = div_r[4];
            default: freq_bit = lf_s2_r;
        endcase
    end
    wire [1:0] mode = ctl_r[clock_regs_pkg::CTL_MODE_LSB +: 2];
    wire tp_nxt = pwm_sel_in ? pwm_in :
                  mode == 2'h0 ? 1'b0 :
                  mode == 2'h1 ? 1'b1 : freq_bit;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) test_pin_out <= 1'b0;
        else          test_pin_out <= tp_nxt;
    end

    // Read data, unused bits read zero
    always_comb begin
        case (a)
            clock_regs_pkg::ADDR_PROTECT:  sfr_rdata_out = protect_r;
            clock_regs_pkg::ADDR_IRQ_EN:   sfr_rdata_out = ien_r;
            clock_regs_pkg::ADDR_IRQ_FLAG: sfr_rdata_out = flag_r;
            clock_regs_pkg::ADDR_CONTROL:  sfr_rdata_out = ctl_r;
            clock_regs_pkg::ADDR_TRIM:     sfr_rdata_out = trim_r;
            clock_regs_pkg::ADDR_SEC_LIM:  sfr_rdata_out = {2'h0, sec_lim_r};
            clock_regs_pkg::ADDR_ALM_MIN:  sfr_rdata_out = {2'h0, alm_min_r};
            clock_regs_pkg::ADDR_ALM_HR:   sfr_rdata_out = {3'h0, alm_hr_r};
            clock_regs_pkg::ADDR_SEC:      sfr_rdata_out = {2'h0, sec_r};
            clock_regs_pkg::ADDR_MIN:      sfr_rdata_out = {2'h0, min_r};
            clock_regs_pkg::ADDR_HR:       sfr_rdata_out = {3'h0, hr_r};
            clock_regs_pkg::ADDR_DAY:      sfr_rdata_out = {3'h0, day_r};
            clock_regs_pkg::ADDR_MONTH:    sfr_rdata_out = {4'h0, mon_r};
            clock_regs_pkg::ADDR_YEAR:     sfr_rdata_out = {1'b0, year_r};
            clock_regs_pkg::ADDR_WEEKDAY:  sfr_rdata_out = {5'h00, wday_r};
            default:                       sfr_rdata_out = 8'h00;
        endcase
    end
endmodule

// ### logic/clock_regs_pkg.sv
// Package: register map, field positions, timing constants for the clock block
package clock_regs_pkg;
    // Register addresses in the special function space
    localparam logic [7:0] ADDR_PROTECT  = 8'h9A;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'hAA;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'hB2;
    localparam logic [7:0] ADDR_CONTROL  = 8'hF1;
    localparam logic [7:0] ADDR_TRIM     = 8'hF2;
    localparam logic [7:0] ADDR_SEC_LIM  = 8'hF3;
    localparam logic [7:0] ADDR_ALM_MIN  = 8'hF4;
    localparam logic [7:0] ADDR_ALM_HR   = 8'hF5;
    localparam logic [7:0] ADDR_SEC      = 8'hF9;
    localparam logic [7:0] ADDR_MIN      = 8'hFA;
    localparam logic [7:0] ADDR_HR       = 8'hFB;
    localparam logic [7:0] ADDR_DAY      = 8'hFC;
    localparam logic [7:0] ADDR_MONTH    = 8'hFD;
    localparam logic [7:0] ADDR_YEAR     = 8'hFE;
    localparam logic [7:0] ADDR_WEEKDAY  = 8'hFF;
    // Reset values
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    // Flag bit positions
    localparam int FLAG_SEC  = 0;
    localparam int FLAG_MIN  = 1;
    localparam int FLAG_HR   = 2;
    localparam int FLAG_DAY  = 3;
    localparam int FLAG_T1   = 4;
    localparam int FLAG_T2   = 5;
    localparam int FLAG_SCNT = 6;
    localparam int FLAG_ALM  = 7;
    // Control field positions
    localparam int CTL_FREQ_LSB = 0;
    localparam int CTL_TICK     = 3;
    localparam int CTL_SCNT_EN  = 4;
    localparam int CTL_MODE_LSB = 5;
    // Protect passwords and mode
    localparam logic [4:0] PASS_MODE  = 5'h18;
    localparam logic [4:0] PASS_OPEN  = 5'h13;
    localparam logic [4:0] PASS_CLOCK = 5'h11;
    localparam logic [4:0] PASS_CLOSE = 5'h15;
    localparam logic [1:0] MODE_OPEN  = 2'h3;
    // Protect window length in system clock cycles
    localparam int WINDOW_CYCLES = 128;
    // Value ranges
    localparam logic [7:0] MAX_SEC  = 8'h3B;
    localparam logic [7:0] MAX_HR   = 8'h17;
    localparam logic [7:0] MAX_MON  = 8'h0C;
    localparam logic [7:0] MAX_YEAR = 8'h7F;
    localparam logic [7:0] MAX_WDAY = 8'h06;
    localparam int TRIM_PERIOD_S = 12;
    // Bus request carried as one bundle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_type;
endpackage
